// file: common/clsf_pkg.sv
// Constants, field layout and carriers for the closed-loop stop/tacho config bank
// Assumes an AXI4-Lite host with 32-bit data; registers live at word offsets
// Function
// - Tacho divider: codes 0,1 divide by 1
// - Cutoff mode 1 stops tacho below threshold
// - Back-EMF threshold codes 0-5 select millivolts
// - Speed regulation off selects torque mode
// - Stop method field selects stop action
// - Brake duration codes map to milliseconds
// - Spin-down threshold percent of maximum speed
// - Brake speed threshold uses same percent code
// - Bits 15-8 hold phase resistance code
// - Bits 7-0 hold phase inductance code
// - Stop register at 8Ah, resets zero, bit31 rw
`default_nettype none
package clsf_pkg;
  // Printed offsets are not all multiples of four: they are word indices
  localparam logic [7:0] CLSF_IDX_STOP = 8'h8A;
  localparam logic [7:0] CLSF_IDX_TACHO = 8'h88;
  localparam logic [9:0] CLSF_ADDR_STOP = {CLSF_IDX_STOP, 2'b00};
  localparam logic [9:0] CLSF_ADDR_TACHO = {CLSF_IDX_TACHO, 2'b00};
  localparam logic [31:0] CLSF_STOP_RST = 32'h0000_0000;
  localparam logic [31:0] CLSF_TACHO_RST = 32'h0000_0000;
  localparam logic [31:0] CLSF_TACHO_WMASK = 32'h0000_0FF3;
  localparam int CLSF_CLK_KHZ = 50000;
  localparam int CLSF_MS_CYCLES = CLSF_CLK_KHZ;
  localparam logic [1:0] CLSF_RESP_OKAY = 2'b00;
  localparam logic [1:0] CLSF_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    CLSF_STOP_HIZ = 3'b000,
    CLSF_STOP_NA = 3'b001,
    CLSF_STOP_LOW_BRAKE = 3'b010,
    CLSF_STOP_HIGH_BRAKE = 3'b011,
    CLSF_STOP_SPIN_DOWN = 3'b100,
    CLSF_STOP_ALIGN_BRAKE = 3'b101,
    CLSF_STOP_UND6 = 3'b110,
    CLSF_STOP_UND7 = 3'b111
  } clsf_stop_t;

  typedef struct packed {
    logic reserved31;
    logic [2:0] stop_method;
    logic [3:0] stop_brake_duration;
    logic [3:0] spin_down_threshold;
    logic [3:0] brake_speed_threshold;
    logic [7:0] phase_resistance_code;
    logic [7:0] phase_inductance_code;
  } clsf_stop_reg_t;

  typedef struct packed {
    logic [19:0] upper;
    logic [3:0] tacho_divider;
    logic tacho_cutoff_mode;
    logic [2:0] tacho_backemf_threshold;
    logic surge_guard_enable;
    logic deadtime_comp_enable;
    logic speed_regulation_off;
    logic reserved0;
  } clsf_tacho_reg_t;

  typedef struct packed {
    logic [2:0] stop_method;
    logic [15:0] brake_ms;
    logic [11:0] spin_down_permille;
    logic [11:0] brake_speed_permille;
    logic [3:0] tacho_div;
    logic [5:0] backemf_mv;
    logic torque_mode;
  } clsf_decoded_t;
endpackage
`default_nettype wire

// file: hdl/clsf_tacho_div.sv
// Tacho output divider with optional back-EMF cutoff
// Assumes pulse_in is a one-cycle pulse synchronous to aclk
`timescale 1ns/100ps
`default_nettype none
module clsf_tacho_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] div_code,
  input wire logic cutoff_mode,
  input wire logic driven,
  input wire logic below_thr,
  input wire logic pulse_in,
  output logic tacho_q
);
  logic [3:0] cnt_q;
  logic [3:0] limit;
  logic active;

  assign limit = (div_code < 4'h2) ? 4'h1 : div_code;
  // Mode 0 runs while driven; mode 1 also needs back-EMF at or above threshold
  assign active = driven && !(cutoff_mode && below_thr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 4'h0;
    end else if (!active) begin
      cnt_q <= 4'h0;
    end else if (pulse_in) begin
      cnt_q <= (cnt_q + 4'h1 >= limit) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tacho_q <= 1'b0;
    end else if (!active) begin
      tacho_q <= 1'b0;
    end else if (pulse_in && (cnt_q + 4'h1 >= limit)) begin
      tacho_q <= ~tacho_q;
    end
  end

  property p_tacho_idle;
    @(posedge aclk) disable iff (!aresetn)
      !active |=> !tacho_q;
  endproperty
  a_tacho_idle: assert property (p_tacho_idle)
    else $error("tacho output high while cut off");

  property p_div1;
    @(posedge aclk) disable iff (!aresetn)
      active && pulse_in && div_code < 4'h2 && $stable(div_code) |=> tacho_q != $past(tacho_q);
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one missed a toggle");
endmodule
`default_nettype wire

// file: hdl/clsf_config_bank.sv
// AXI4-Lite register bank for closed-loop stop and tacho configuration
// Assumes one outstanding write and one read; motor core drives status inputs
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module clsf_config_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic motor_driven,
  input wire logic rotor_pulse,
  input wire logic [5:0] back_emf_mv,
  output logic tacho_output,
  output clsf_pkg::clsf_decoded_t cfg_q
);
  ////////////////////////////////////////////////////////////////
  clsf_pkg::clsf_stop_reg_t stop_q;
  clsf_pkg::clsf_tacho_reg_t tacho_q;
  logic [9:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic do_write;
  logic below_thr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = (r & msk) | (old & ~msk);
  endfunction

  function automatic logic [11:0] pct(input logic [3:0] c);
    case (c)
      4'h0: pct = 12'h3E8;
      4'h1: pct = 12'h384;
      4'h2: pct = 12'h320;
      4'h3: pct = 12'h2BC;
      4'h4: pct = 12'h258;
      4'h5: pct = 12'h1F4;
      4'h6: pct = 12'h1C2;
      4'h7: pct = 12'h190;
      4'h8: pct = 12'h15E;
      4'h9: pct = 12'h12C;
      4'hA: pct = 12'h0FA;
      4'hB: pct = 12'h0C8;
      4'hC: pct = 12'h096;
      4'hD: pct = 12'h064;
      4'hE: pct = 12'h032;
      default: pct = 12'h019;
    endcase
  endfunction

  function automatic logic [15:0] brake_ms(input logic [3:0] c);
    case (c)
      4'h5: brake_ms = 16'h0005;
      4'h6: brake_ms = 16'h000A;
      4'h7: brake_ms = 16'h0032;
      4'h8: brake_ms = 16'h0064;
      4'h9: brake_ms = 16'h00FA;
      4'hA: brake_ms = 16'h01F4;
      4'hB: brake_ms = 16'h03E8;
      4'hC: brake_ms = 16'h09C4;
      4'hD: brake_ms = 16'h1388;
      4'hE: brake_ms = 16'h2710;
      4'hF: brake_ms = 16'h3A98;
      default: brake_ms = 16'h0001;
    endcase
  endfunction

  function automatic logic [5:0] emf_thr_mv(input logic [2:0] c);
    case (c)
      3'h0: emf_thr_mv = 6'h01;
      3'h1: emf_thr_mv = 6'h02;
      3'h2: emf_thr_mv = 6'h05;
      3'h3: emf_thr_mv = 6'h0A;
      3'h4: emf_thr_mv = 6'h14;
      3'h5: emf_thr_mv = 6'h1E;
      default: emf_thr_mv = 6'h01;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 10'h000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= clsf_pkg::CLSF_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q[9:2] == clsf_pkg::CLSF_IDX_STOP ||
                      awaddr_q[9:2] == clsf_pkg::CLSF_IDX_TACHO) ?
                     clsf_pkg::CLSF_RESP_OKAY : clsf_pkg::CLSF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registers; undefined codes are stored unchanged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_q <= clsf_pkg::CLSF_STOP_RST;
    end else if (do_write && awaddr_q[9:2] == clsf_pkg::CLSF_IDX_STOP) begin
      stop_q <= merge(stop_q, wdata_q, wstrb_q, 32'hFFFF_FFFF);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tacho_q <= clsf_pkg::CLSF_TACHO_RST;
    end else if (do_write && awaddr_q[9:2] == clsf_pkg::CLSF_IDX_TACHO) begin
      tacho_q <= merge(tacho_q, wdata_q, wstrb_q, clsf_pkg::CLSF_TACHO_WMASK);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= clsf_pkg::CLSF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= clsf_pkg::CLSF_RESP_OKAY;
      if (s_axi_araddr[9:2] == clsf_pkg::CLSF_IDX_STOP) begin
        s_axi_rdata <= stop_q;
      end else if (s_axi_araddr[9:2] == clsf_pkg::CLSF_IDX_TACHO) begin
        s_axi_rdata <= {19'h00000, tacho_output, tacho_q[11:0]};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= clsf_pkg::CLSF_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Decoded settings to the motor core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= '0;
    end else begin
      // Codes 1, 6, 7 fall back to high impedance
      case (stop_q.stop_method)
        clsf_pkg::CLSF_STOP_LOW_BRAKE, clsf_pkg::CLSF_STOP_HIGH_BRAKE,
        clsf_pkg::CLSF_STOP_SPIN_DOWN, clsf_pkg::CLSF_STOP_ALIGN_BRAKE: begin
          cfg_q.stop_method <= stop_q.stop_method;
        end
        default: begin
          cfg_q.stop_method <= clsf_pkg::CLSF_STOP_HIZ;
        end
      endcase
      cfg_q.brake_ms <= brake_ms(stop_q.stop_brake_duration);
      cfg_q.spin_down_permille <= pct(stop_q.spin_down_threshold);
      cfg_q.brake_speed_permille <= pct(stop_q.brake_speed_threshold);
      cfg_q.tacho_div <= (tacho_q.tacho_divider < 4'h2) ? 4'h1 : tacho_q.tacho_divider;
      cfg_q.backemf_mv <= emf_thr_mv(tacho_q.tacho_backemf_threshold);
      cfg_q.torque_mode <= tacho_q.speed_regulation_off;
    end
  end

  assign below_thr = back_emf_mv < emf_thr_mv(tacho_q.tacho_backemf_threshold);

  clsf_tacho_div u_tacho (
    .aclk(aclk),
    .aresetn(aresetn),
    .div_code(tacho_q.tacho_divider),
    .cutoff_mode(tacho_q.tacho_cutoff_mode),
    .driven(motor_driven),
    .below_thr(below_thr),
    .pulse_in(rotor_pulse),
    .tacho_q(tacho_output)
  );

  ////////////////////////////////////////////////////////////////
  property p_stop_hold;
    @(posedge aclk) disable iff (!aresetn)
      !(do_write && awaddr_q[9:2] == clsf_pkg::CLSF_IDX_STOP) |=> $stable(stop_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop reg changed alone");

  property p_stop_write;
    @(posedge aclk) disable iff (!aresetn)
      do_write && awaddr_q[9:2] == clsf_pkg::CLSF_IDX_STOP && wstrb_q == 4'hF
      |=> stop_q == $past(wdata_q);
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("stop reg write lost");

  property p_ind_bits;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == clsf_pkg::CLSF_IDX_STOP
      |=> s_axi_rdata[7:0] == $past(stop_q.phase_inductance_code);
  endproperty
  a_ind_bits: assert property (p_ind_bits) else $error("inductance readback wrong");

  property p_torque;
    @(posedge aclk) disable iff (!aresetn)
      ##1 cfg_q.torque_mode == $past(tacho_q.speed_regulation_off);
  endproperty
  a_torque: assert property (p_torque) else $error("torque mode not following");

  property p_stop_method;
    @(posedge aclk) disable iff (!aresetn)
      stop_q.stop_method == 3'h1 |=> cfg_q.stop_method == clsf_pkg::CLSF_STOP_HIZ;
  endproperty
  a_stop_method: assert property (p_stop_method) else $error("unused stop code acted on");

  property p_brake_min;
    @(posedge aclk) disable iff (!aresetn)
      stop_q.stop_brake_duration < 4'h5 |=> cfg_q.brake_ms == 16'h0001;
  endproperty
  a_brake_min: assert property (p_brake_min) else $error("short brake code not 1 ms");

  property p_pct_last;
    @(posedge aclk) disable iff (!aresetn)
      stop_q.spin_down_threshold == 4'hF && stop_q.brake_speed_threshold == 4'h0
      |=> cfg_q.spin_down_permille == 12'h019 && cfg_q.brake_speed_permille == 12'h3E8;
  endproperty
  a_pct_last: assert property (p_pct_last) else $error("threshold percent wrong");

  property p_emf_thr;
    @(posedge aclk) disable iff (!aresetn)
      tacho_q.tacho_backemf_threshold == 3'h5 |=> cfg_q.backemf_mv == 6'h1E;
  endproperty
  a_emf_thr: assert property (p_emf_thr) else $error("back-emf threshold wrong");

  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response dropped");
endmodule
`default_nettype wire

// file: verif/tb_clsf_config_bank.sv
// Self-checking bench for the closed-loop stop and tacho configuration bank
// Assumes the bank is the only AXI4-Lite slave; the bench drives motor status
`timescale 1ns/100ps
`default_nettype none
module tb_clsf_config_bank;
  logic aclk;
  logic aresetn;
  logic [9:0] awaddr;
  logic [9:0] araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic motor_driven, rotor_pulse, tacho_output;
  logic [5:0] back_emf_mv;
  clsf_pkg::clsf_decoded_t cfg_q;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'h8D07;
  logic [31:0] stop_s, tacho_s, d;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int ms_t[16] = '{1, 1, 1, 1, 1, 5, 10, 50, 100, 250, 500, 1000, 2500, 5000, 10000, 15000};
  int pm_t[16] = '{1000, 900, 800, 700, 600, 500, 450, 400, 350, 300, 250, 200, 150, 100, 50, 25};
  int mv_t[8] = '{1, 2, 5, 10, 20, 30, 1, 1};
  int divs[5] = '{0, 1, 2, 3, 15};

  clsf_config_bank clsf_config_bank_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .motor_driven(motor_driven), .rotor_pulse(rotor_pulse), .back_emf_mv(back_emf_mv),
    .tacho_output(tacho_output), .cfg_q(cfg_q)
  );

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expected decode, worked out from the field tables
  function automatic clsf_pkg::clsf_decoded_t dec(input logic [31:0] s, input logic [31:0] t);
    clsf_pkg::clsf_decoded_t e;
    e.stop_method = (s[30:28] inside {3'h1, 3'h6, 3'h7}) ? 3'h0 : s[30:28];
    e.brake_ms = 16'(ms_t[s[27:24]]);
    e.spin_down_permille = 12'(pm_t[s[23:20]]);
    e.brake_speed_permille = 12'(pm_t[s[19:16]]);
    e.tacho_div = (t[11:8] < 4'h2) ? 4'h1 : t[11:8];
    e.backemf_mv = 6'(mv_t[t[6:4]]);
    e.torque_mode = t[1];
    return e;
  endfunction

  task automatic wr(input logic [9:0] a, input logic [31:0] dd, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dd;
    wstrb <= s;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      // Late bready makes the response wait stalled
      if (n == 3) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 50);
    bready <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    rq.push_back({er, ed});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge aclk) rotor_pulse <= 1'b1;
      @(posedge aclk) rotor_pulse <= 1'b0;
      @(posedge aclk);
    end
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher: oldest expectation against each completed response
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
      check("read", {rresp, rdata}, rq.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) begin
      check("bresp", bresp, bq.pop_front());
    end
  end

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    {wdata, wstrb, motor_driven, rotor_pulse, back_emf_mv} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("cfg_rst", cfg_q, dec(32'h0, 32'h0));
    rd(clsf_pkg::CLSF_ADDR_STOP, 32'h0000_0000, clsf_pkg::CLSF_RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      stop_s = {d[31], 3'(i), 4'(i), 4'(i), 4'(15 - i), d[15:0]};
      wr(clsf_pkg::CLSF_ADDR_STOP, stop_s, 4'hF, clsf_pkg::CLSF_RESP_OKAY);
      rd(clsf_pkg::CLSF_ADDR_STOP, stop_s, clsf_pkg::CLSF_RESP_OKAY);
      d = $random(seed);
      tacho_s = {d[31:12], 4'(i), d[7], 3'(i), d[3:0]};
      wr(clsf_pkg::CLSF_ADDR_TACHO, tacho_s, 4'hF, clsf_pkg::CLSF_RESP_OKAY);
      rd(clsf_pkg::CLSF_ADDR_TACHO, tacho_s & clsf_pkg::CLSF_TACHO_WMASK,
         clsf_pkg::CLSF_RESP_OKAY);
      check("cfg", cfg_q, dec(stop_s, tacho_s));
    end
    // Single byte lane, then an unmapped place
    wr(clsf_pkg::CLSF_ADDR_STOP, 32'hFFFF_FFFF, 4'h4, clsf_pkg::CLSF_RESP_OKAY);
    stop_s[23:16] = 8'hFF;
    rd(clsf_pkg::CLSF_ADDR_STOP, stop_s, clsf_pkg::CLSF_RESP_OKAY);
    wr(10'h3FC, 32'h5A5A_A5A5, 4'hF, clsf_pkg::CLSF_RESP_SLVERR);
    rd(10'h3FC, 32'h0000_0000, clsf_pkg::CLSF_RESP_SLVERR);
    rd(clsf_pkg::CLSF_ADDR_STOP, stop_s, clsf_pkg::CLSF_RESP_OKAY);
    // Divider codes, then stop driving
    foreach (divs[j]) begin
      wr(clsf_pkg::CLSF_ADDR_TACHO, {20'h0, 4'(divs[j]), 8'h00}, 4'hF,
         clsf_pkg::CLSF_RESP_OKAY);
      motor_driven <= 1'b1;
      pulses((divs[j] < 2) ? 0 : divs[j] - 1);
      check("tacho_pre", tacho_output, 1'b0);
      pulses(1);
      check("tacho_edge", tacho_output, 1'b1);
      motor_driven <= 1'b0;
      repeat (2) @(posedge aclk);
      check("tacho_idle", tacho_output, 1'b0);
    end
    // Cutoff mode at a 10 mV threshold
    wr(clsf_pkg::CLSF_ADDR_TACHO, 32'h0000_02B0, 4'hF, clsf_pkg::CLSF_RESP_OKAY);
    back_emf_mv <= 6'h09;
    motor_driven <= 1'b1;
    pulses(4);
    check("tacho_cut", tacho_output, 1'b0);
    back_emf_mv <= 6'h0A;
    pulses(2);
    check("tacho_on", tacho_output, 1'b1);
    motor_driven <= 1'b0;
    repeat (2) @(posedge aclk);
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("cfg_rst2", cfg_q, dec(32'h0, 32'h0));
    check("tacho_rst", tacho_output, 1'b0);
    rd(clsf_pkg::CLSF_ADDR_STOP, 32'h0000_0000, clsf_pkg::CLSF_RESP_OKAY);
    rd(clsf_pkg::CLSF_ADDR_TACHO, 32'h0000_0000, clsf_pkg::CLSF_RESP_OKAY);
    repeat (3) @(posedge aclk);
    stop_test();
  end
endmodule
`default_nettype wire
